/* dv/fw_bus_model.sv */
// firmware side model: register bus master for the tick timer
`timescale 1ns/1ps
module fw_bus_model
  import rtos_timer_pkg::*;
(
  input wire logic core_clk,
  output reg_req_t reg_req,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rd_valid
);
  // ==========================================================
  // bus cycles
  // strobes rise just after an edge and stay up for one taken edge
  initial reg_req = '0;

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    #1 reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    // released lines show the inverse so a stale word cannot pass
    #1 reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // read data and valid are taken just after the taken edge, once the registered answer is out
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic v);
    @(posedge core_clk);
    #1 reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'hffff_ffff};
    @(posedge core_clk);
    #1 reg_req.rd = 1'b0;
    d = reg_rdata;
    v = reg_rd_valid;
  endtask
endmodule

/* dv/rtos_down_timer_control_bench.sv */
// self-checking bench for the tick timer
`timescale 1ns/1ps
`include "rtos_timer_params.svh"
module rtos_down_timer_control_bench
  import rtos_timer_pkg::*;
;
  logic core_clk;
  logic rst_b;
  logic timer_tick;
  logic halt_in;
  reg_req_t reg_req;
  logic [31:0] reg_rdata;
  logic reg_rd_valid;
  logic [31:0] current_count;
  logic expiry_pulse;
  logic timer_clk_run;
  int n_fail = 0;
  int checks_done = 0;
  int n_pulse = 0;
  localparam logic [7:0] SV = `RT_OFS_START_VALUE;
  localparam logic [7:0] CT = `RT_OFS_CONTROL;

  // ==========================================================
  // instances
  rtos_down_timer_control dut_u (.core_clk(core_clk), .rst_b(rst_b), .reg_req(reg_req),
    .timer_tick(timer_tick), .halt_in(halt_in), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .current_count(current_count), .expiry_pulse(expiry_pulse), .timer_clk_run(timer_clk_run));
  fw_bus_model fw_u (.core_clk(core_clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid));

  // ==========================================================
  // clock and pulse tally
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (expiry_pulse === 1'b1) n_pulse++;
  end

  // ==========================================================
  // helpers
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", what, e, g);
      n_fail++;
    end
  endtask
  // each tick is a one-cycle pulse followed by an idle cycle
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1 timer_tick = 1'b1;
      @(posedge core_clk);
      #1 timer_tick = 1'b0;
    end
  endtask
  // one idle cycle first, so a write's effect has landed
  task automatic cnt(input logic [31:0] e);
    @(posedge core_clk);
    #1 chk("current_count", e, current_count);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic v;
    fw_u.rd(a, d, v);
    chk("reg_rd_valid", 32'h1, {31'h0, v});
    chk("reg_rdata", e, d);
  endtask
  task automatic pul(input int e);
    chk("expiry_pulse tally", 32'(e), 32'(n_pulse));
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rdc(SV, 32'h0);
    rdc(CT, 32'h0);
    rdc(8'h0c, 32'h0);
    chk("timer_clk_run", 32'h0, {31'h0, timer_clk_run});
    $display("test reset_values done");
  endtask
  task automatic t_oneshot();
    fw_u.wr(SV, 32'h3);
    fw_u.wr(CT, 32'h5);
    cnt(32'h3);
    chk("timer_clk_run", 32'h1, {31'h0, timer_clk_run});
    ticks(2);
    cnt(32'h1);
    pul(0);
    ticks(1);
    cnt(32'h0);
    pul(1);
    rdc(CT, 32'h1);
    ticks(2);
    cnt(32'h0);
    pul(1);
    fw_u.wr(CT, 32'h5);
    cnt(32'h3);
    $display("test one_shot done");
  endtask
  task automatic t_halt();
    fw_u.wr(CT, 32'h15);
    ticks(2);
    cnt(32'h3);
    fw_u.wr(CT, 32'h0d);
    halt_in = 1'b1;
    ticks(2);
    cnt(32'h3);
    halt_in = 1'b0;
    ticks(1);
    cnt(32'h2);
    fw_u.wr(CT, 32'h05);
    halt_in = 1'b1;
    ticks(1);
    cnt(32'h1);
    halt_in = 1'b0;
    fw_u.wr(CT, 32'h01);
    cnt(32'h0);
    pul(1);
    $display("test halts_and_clear done");
  endtask
  task automatic t_cont();
    fw_u.wr(SV, 32'h2);
    fw_u.wr(CT, 32'h7);
    ticks(1);
    fw_u.wr(SV, 32'h4);
    cnt(32'h1);
    ticks(1);
    cnt(32'h0);
    pul(2);
    ticks(1);
    cnt(32'h4);
    pul(2);
    ticks(4);
    rdc(CT, 32'h7);
    pul(3);
    ticks(1);
    cnt(32'h4);
    fw_u.wr(SV, 32'h0);
    cnt(32'h0);
    rdc(CT, 32'h3);
    fw_u.wr(CT, 32'h7);
    rdc(CT, 32'h3);
    pul(3);
    $display("test continuous done");
  endtask
  task automatic t_disable();
    fw_u.wr(SV, 32'h6);
    fw_u.wr(CT, 32'h1f);
    cnt(32'h6);
    fw_u.wr(CT, 32'h0);
    cnt(32'h0);
    rdc(SV, 32'h0);
    chk("timer_clk_run", 32'h0, {31'h0, timer_clk_run});
    fw_u.wr(SV, 32'h9);
    rdc(SV, 32'h9);
    fw_u.wr(CT, 32'h4);
    ticks(2);
    cnt(32'h9);
    rdc(CT, 32'h4);
    $display("test disable done");
  endtask
  // reset with the counter loaded but enable low must bring registers and counter back to zero
  task automatic t_por();
    rst_b = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 rst_b = 1'b1;
    cnt(32'h0);
    rdc(SV, 32'h0);
    rdc(CT, 32'h0);
    chk("timer_clk_run", 32'h0, {31'h0, timer_clk_run});
    $display("test reset_again done");
  endtask

  // ==========================================================
  // verdict and main sequence
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  initial begin
    #100000;
    n_fail++;
    give_verdict();
  end
  initial begin
    rst_b = 1'b0;
    timer_tick = 1'b0;
    halt_in = 1'b0;
    repeat (12) @(posedge core_clk);
    #1 rst_b = 1'b1;
    t_reset();
    t_oneshot();
    t_halt();
    t_cont();
    t_disable();
    t_por();
    give_verdict();
  end
endmodule

/* src/down_count_core.sv */
// down counter core with load, clear, step and reload
`timescale 1ns/1ps
module down_count_core
  import rtos_timer_pkg::*;
#(
  parameter int W = 32
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire counter_cmd_t cmd,
  input wire logic [W-1:0] reload_value,
  output logic [W-1:0] count,
  output logic expired
);

  localparam logic [W-1:0] COUNT_ZERO = '0;
  localparam logic [W-1:0] COUNT_ONE = W'(1);

  logic [W-1:0] next_count;
  logic next_expired;

  if (W < 2) begin : g_bad_width
    $error("down_count_core: W must be at least 2");
  end

  // ==========================================================
  // next count; clear beats load beats step
  always_comb begin
    next_count = count;
    next_expired = 1'b0;
    if (cmd.clear) begin
      next_count = COUNT_ZERO; // no expiry on a firmware stop (see [RL8])
    end else if (cmd.load) begin
      next_count = reload_value; // see [RL7]
    end else if (cmd.step) begin
      if (count == COUNT_ZERO) begin
        // reload reads the live start value, so late writes land here
        next_count = cmd.auto_reload ? reload_value : COUNT_ZERO; // see [RL12] see [RL2]
      end else begin
        next_count = count - COUNT_ONE; // see [RL18]
        next_expired = (count == COUNT_ONE); // see [RL16]
      end
    end
  end

  // ==========================================================
  // count registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
      expired <= 1'b0;
    end else begin
      count <= next_count;
      expired <= next_expired;
    end
  end

endmodule

/* src/rtos_down_timer_control.sv */
// 32-bit operating-system tick timer: registers, control and counter
// What this block does
// [RL1] 32-bit start value register, reset to zero
// [RL2] late start value used only at auto reload
// [RL3] firmware writes start value before start bit
// [RL4] writing zero start value stops and clears start
// [RL5] firmware halt bit freezes the counter
// [RL6] enable bit gates the external halt input
// [RL7] setting start loads start value, begins counting
// [RL8] clearing start zeroes counter, no interrupt
// [RL9] start self-clears on one-shot expiry or zeros
// [RL10] auto reload never clears start by itself; code still clears it when start value and counter are both zero
// [RL11] one-shot mode waits done after expiry
// [RL12] continuous mode reloads from start value
// [RL13] enable low gates timer, lowest power
// [RL14] enable falling edge restores all defaults
// [RL15] registers always accessible regardless of enable
// [RL16] one pulse when counter steps one to zero
// [RL17] external halt high stops, low resumes counting
// [RL18] decrement once per timer tick while running
`timescale 1ns/1ps
`include "rtos_timer_params.svh"
module rtos_down_timer_control
  import rtos_timer_pkg::*;
#(
  parameter int COUNT_W = 32
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire reg_req_t reg_req,
  input wire logic timer_tick,
  input wire logic halt_in,
  output logic [`RT_DATA_W-1:0] reg_rdata,
  output logic reg_rd_valid,
  output logic [COUNT_W-1:0] current_count,
  output logic expiry_pulse,
  output logic timer_clk_run
);

  localparam logic [COUNT_W-1:0] COUNT_ZERO = '0;
  localparam logic [COUNT_W-1:0] COUNT_ONE = COUNT_W'(1);

  if (COUNT_W < 2 || COUNT_W > `RT_DATA_W) begin : g_bad_width
    $error("rtos_down_timer_control: COUNT_W must be 2 to 32");
  end

  // ==========================================================
  // state
  ctrl_t ctrl;
  ctrl_t next_ctrl;
  ctrl_t new_ctrl;
  logic [COUNT_W-1:0] start_value;
  logic [COUNT_W-1:0] next_start_value;
  logic [`RT_DATA_W-1:0] next_rdata;
  logic next_rd_valid;
  logic wr_start_value;
  logic wr_ctrl;
  logic wr_zero;
  logic enable_fall;
  logic halted;
  logic step;
  logic hw_clear;
  counter_cmd_t cmd;

  // ==========================================================
  // decode and control next values
  always_comb begin
    wr_start_value = reg_req.wr && (reg_req.addr == `RT_OFS_START_VALUE); // see [RL15]
    wr_ctrl = reg_req.wr && (reg_req.addr == `RT_OFS_CONTROL); // see [RL15]
    wr_zero = wr_start_value && (reg_req.wdata[COUNT_W-1:0] == COUNT_ZERO);
    new_ctrl = ctrl_t'(reg_req.wdata[`RT_CTRL_W-1:0]);
    enable_fall = wr_ctrl && ctrl.enable && !new_ctrl.enable;
    halted = ctrl.fw_halt || (ctrl.hw_halt_en && halt_in); // see [RL5] see [RL6] see [RL17]
    step = ctrl.enable && ctrl.start && !halted && timer_tick; // see [RL13] see [RL18]
    // only one-shot expiry and the all-zero case end a run
    hw_clear = (step && (current_count == COUNT_ONE) && !ctrl.auto_reload) // see [RL9] see [RL11] see [RL10]
      || (ctrl.start && (start_value == COUNT_ZERO) && (current_count == COUNT_ZERO)); // see [RL9]
    next_ctrl = ctrl;
    next_start_value = start_value;
    if (hw_clear) begin
      next_ctrl.start = 1'b0;
    end
    if (wr_start_value) begin
      next_start_value = reg_req.wdata[COUNT_W-1:0]; // see [RL1]
      if (wr_zero) begin
        next_ctrl.start = 1'b0; // see [RL4]
      end
    end
    // a firmware write of the start bit wins over a hardware clear
    if (wr_ctrl) begin
      next_ctrl = new_ctrl;
    end
    if (enable_fall) begin
      next_ctrl = ctrl_t'(`RT_CTRL_RESET); // see [RL14]
      next_start_value = COUNT_W'(`RT_START_VALUE_RESET); // see [RL14]
    end
    cmd.clear = enable_fall || wr_zero || (wr_ctrl && ctrl.start && !new_ctrl.start); // see [RL8] see [RL4]
    // restart also when start is being self-cleared in this cycle
    cmd.load = wr_ctrl && new_ctrl.start && (!ctrl.start || hw_clear); // see [RL7]
    cmd.step = step;
    cmd.auto_reload = ctrl.auto_reload; // see [RL12]
  end

  // control registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= ctrl_t'(`RT_CTRL_RESET);
      start_value <= COUNT_W'(`RT_START_VALUE_RESET);
    end else begin
      ctrl <= next_ctrl;
      start_value <= next_start_value;
    end
  end

  // ==========================================================
  // read path, answered one cycle after the request
  always_comb begin
    next_rd_valid = reg_req.rd;
    next_rdata = `RT_RDATA_RESET;
    if (reg_req.rd && reg_req.addr == `RT_OFS_START_VALUE) begin
      next_rdata = `RT_DATA_W'(start_value);
    end else if (reg_req.rd && reg_req.addr == `RT_OFS_CONTROL) begin
      next_rdata = `RT_DATA_W'(ctrl); // reserved bits read zero
    end
  end

  // read registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= `RT_RDATA_RESET;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      reg_rd_valid <= next_rd_valid;
    end
  end

  // ==========================================================
  // counter core and clock gate request
  down_count_core #(
    .W(COUNT_W)
  ) u_core (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .cmd(cmd),
    .reload_value(start_value),
    .count(current_count),
    .expired(expiry_pulse)
  );

  // timer clock may only run while enabled
  assign timer_clk_run = ctrl.enable; // see [RL13]

  // ==========================================================
  // checks
  a_start_loads_count: assert property (@(posedge core_clk) disable iff (!rst_b) // see [RL7]
    wr_ctrl && !ctrl.start && new_ctrl.start && !enable_fall |=> current_count == $past(start_value))
    else $error("start did not load start value");

  a_stop_zeroes_count: assert property (@(posedge core_clk) disable iff (!rst_b) // see [RL8]
    wr_ctrl && ctrl.start && !new_ctrl.start |=> current_count == COUNT_ZERO && !expiry_pulse)
    else $error("stop did not zero counter quietly");

  a_zero_value_stops: assert property (@(posedge core_clk) disable iff (!rst_b) // see [RL4]
    wr_zero |=> !ctrl.start && current_count == COUNT_ZERO)
    else $error("zero start value did not stop timer");

  a_fw_halt_freeze: assert property (@(posedge core_clk) disable iff (!rst_b) // see [RL5]
    ctrl.fw_halt && !wr_ctrl && !wr_start_value |=> $stable(current_count))
    else $error("counter moved under firmware halt");

  a_hw_halt_freeze: assert property (@(posedge core_clk) disable iff (!rst_b) // see [RL17]
    ctrl.hw_halt_en && halt_in && !wr_ctrl && !wr_start_value |=> $stable(current_count))
    else $error("counter moved under external halt");

  a_hw_halt_ignored: assert property (@(posedge core_clk) disable iff (!rst_b) // see [RL6]
    ctrl.enable && ctrl.start && !ctrl.fw_halt && !ctrl.hw_halt_en && halt_in && timer_tick
    && current_count > COUNT_ONE && !wr_ctrl && !wr_start_value
    |=> current_count == $past(current_count) - COUNT_ONE)
    else $error("disabled halt input stopped counter");

  a_pulse_on_one: assert property (@(posedge core_clk) disable iff (!rst_b) // see [RL16]
    expiry_pulse |-> $past(current_count) == COUNT_ONE && current_count == COUNT_ZERO ##1 !expiry_pulse)
    else $error("expiry pulse not tied to one-to-zero step");

  a_oneshot_done: assert property (@(posedge core_clk) disable iff (!rst_b) // see [RL11]
    step && !ctrl.auto_reload && current_count == COUNT_ONE && !wr_ctrl
    |=> !ctrl.start && current_count == COUNT_ZERO)
    else $error("one-shot did not finish done");

  a_auto_keeps_start: assert property (@(posedge core_clk) disable iff (!rst_b) // see [RL10]
    ctrl.start && ctrl.auto_reload && start_value != COUNT_ZERO && !wr_ctrl && !wr_start_value |=> ctrl.start)
    else $error("auto reload cleared start");

  a_auto_reload: assert property (@(posedge core_clk) disable iff (!rst_b) // see [RL12]
    step && ctrl.auto_reload && current_count == COUNT_ZERO && !wr_ctrl && !wr_start_value
    |=> current_count == $past(start_value))
    else $error("continuous mode did not reload");

  a_enable_fall: assert property (@(posedge core_clk) disable iff (!rst_b) // see [RL14]
    enable_fall |=> ctrl == ctrl_t'(`RT_CTRL_RESET) && start_value == COUNT_ZERO && !timer_clk_run
    && current_count == COUNT_ZERO)
    else $error("enable fall did not restore defaults");

  a_disabled_frozen: assert property (@(posedge core_clk) disable iff (!rst_b) // see [RL13]
    !ctrl.enable && !wr_ctrl && !wr_start_value |=> $stable(current_count) && !expiry_pulse)
    else $error("counter ran while disabled");

endmodule

/* src/rtos_timer_params.svh */
// offsets, field positions and reset values of the tick timer
`ifndef RTOS_TIMER_PARAMS_SVH
`define RTOS_TIMER_PARAMS_SVH

// ==========================================================
// register bus shape
`define RT_DATA_W 32
`define RT_ADDR_W 8

// ==========================================================
// register byte offsets
`define RT_OFS_START_VALUE 8'h04
`define RT_OFS_CONTROL 8'h08

// ==========================================================
// control field positions and width
`define RT_BIT_ENABLE 0
`define RT_BIT_AUTO_RELOAD 1
`define RT_BIT_START 2
`define RT_BIT_HW_HALT_EN 3
`define RT_BIT_FW_HALT 4
`define RT_CTRL_W 5

// ==========================================================
// reset values
`define RT_CTRL_RESET 5'h00
`define RT_START_VALUE_RESET 32'h0000_0000
`define RT_RDATA_RESET 32'h0000_0000

`endif

/* src/rtos_timer_pkg.sv */
// types shared by the tick timer files
package rtos_timer_pkg;

  // ==========================================================
  // control register image, msb first to match bit positions
  typedef struct packed {
    logic fw_halt;
    logic hw_halt_en;
    logic start;
    logic auto_reload;
    logic enable;
  } ctrl_t;

  // register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  // command to the down counter core
  typedef struct packed {
    logic clear;
    logic load;
    logic step;
    logic auto_reload;
  } counter_cmd_t;

endpackage
